// ===== src/bal_pkg.sv
// Purpose: shared constants, types and helpers of the borrow and logic accumulator datapath
// Assumes: one clock core_clk at 100 MHz, synchronous active-high reset
// Notes:   Operation
// Operation
// RULE_01: subtract sets sign, zero, overflow, half-borrow, subtract, carry
// RULE_02: subtract operand from accumulator, store difference
// RULE_03: borrow subtract removes operand and carry
// RULE_04: borrow subtract flags: subtract, half-borrow, carry, overflow
// RULE_05: sign and zero follow every result
// RULE_06: bitwise and into accumulator
// RULE_07: and sets half-carry, clears subtract, carry
// RULE_08: bitwise or into accumulator
// RULE_09: or clears half-carry, subtract, carry
// RULE_10: exclusive or into accumulator
// RULE_11: exclusive or: parity even flag, clear others
// RULE_12: register field codes b,c,d,e,h,l,a
// RULE_13: five operand forms, index prefixes with displacement
// RULE_14: signed displacement added to index pair
// RULE_15: timing 4, 7 and 19 t states
// RULE_16: register form is op prefix plus register
// RULE_17: exclusive or immediate ee, pointer ae

package bal_pkg;

   // ---
   // timing
   // ---
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_STATE_NS    = 250;
   localparam int T_DIV_DEFAULT = (T_STATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [4:0] T_REG_FORM   = 5'h04;
   localparam logic [4:0] T_SHORT_FORM = 5'h07;
   localparam logic [4:0] T_INDEX_FORM = 5'h13;
   localparam logic [4:0] T_MEM_CYCLE  = 5'h03;

   // ---
   // instruction encoding
   // ---
   localparam logic [7:0] PREFIX_NONE       = 8'h00;
   localparam logic [7:0] PREFIX_FIRST_IDX  = 8'hdd;
   localparam logic [7:0] PREFIX_SECOND_IDX = 8'hfd;
   localparam logic [1:0] ROW_REG   = 2'h2;
   localparam logic [1:0] ROW_IMM   = 2'h3;
   localparam logic [2:0] PTR_FIELD = 3'h6;
   localparam logic [2:0] OPF_SUB   = 3'h2;
   localparam logic [2:0] OPF_SBC   = 3'h3;
   localparam logic [2:0] OPF_AND   = 3'h4;
   localparam logic [2:0] OPF_XOR   = 3'h5;
   localparam logic [2:0] OPF_OR    = 3'h6;
   localparam logic [2:0] REG_B = 3'h0;
   localparam logic [2:0] REG_C = 3'h1;
   localparam logic [2:0] REG_D = 3'h2;
   localparam logic [2:0] REG_E = 3'h3;
   localparam logic [2:0] REG_H = 3'h4;
   localparam logic [2:0] REG_L = 3'h5;
   localparam logic [2:0] REG_A = 3'h7;

   // ---
   // flag layout and reset values
   // ---
   localparam int FLAG_S_BIT  = 7;
   localparam int FLAG_Z_BIT  = 6;
   localparam int FLAG_H_BIT  = 4;
   localparam int FLAG_PV_BIT = 2;
   localparam int FLAG_N_BIT  = 1;
   localparam int FLAG_C_BIT  = 0;
   localparam logic [7:0] ACC_RESET   = 8'h00;
   localparam logic [7:0] FLAGS_RESET = 8'h00;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN  = 2'h1,
      ST_DONE = 2'h3
   } bal_state_e;

   typedef enum logic [1:0] {
      FORM_REG = 2'h0,
      FORM_IMM = 2'h1,
      FORM_PTR = 2'h2,
      FORM_IDX = 2'h3
   } bal_form_e;

   function automatic logic bal_op_known(input logic [2:0] opf);
      return (opf == OPF_SUB) || (opf == OPF_SBC) || (opf == OPF_AND) ||
             (opf == OPF_XOR) || (opf == OPF_OR);
   endfunction

   function automatic logic bal_parity_even(input logic [7:0] v);
      return ~(^v);
   endfunction

endpackage

// ===== src/bal_alu_if.sv
// Purpose: operand and result bundle between sequencer and arithmetic unit
// Assumes: purely combinational path from operands to result
// Notes:   core drives operands, alu returns result and flags
`timescale 1ns/100ps
`default_nettype none

interface bal_alu_if;
   logic [2:0] op;
   logic [7:0] a;
   logic [7:0] b;
   logic       cin;
   logic [7:0] res;
   logic [7:0] flags;

   modport core (output op, output a, output b, output cin, input res, input flags);
   modport alu  (input op, input a, input b, input cin, output res, output flags);
endinterface

`default_nettype wire

// ===== src/bal_alu.sv
// Purpose: combinational subtract and bitwise unit with flag generation
// Assumes: operands stable while the sequencer writes back
// Notes:   bits 5 and 3 of the flag byte read zero
`timescale 1ns/100ps
`default_nettype none

module bal_alu
   import bal_pkg::*;
(
   bal_alu_if.alu port_if
);

   always_comb
   begin
      logic       bin;
      logic [8:0] diff9;
      logic [4:0] nib5;
      logic [7:0] r;
      logic [7:0] f;
      bin   = 1'b0;
      diff9 = 9'h000;
      nib5  = 5'h00;
      r     = port_if.a;
      f     = 8'h00;
      if (port_if.op == OPF_SBC)
      begin
         bin = port_if.cin;                                          // [RULE_03]
      end
      diff9 = {1'b0, port_if.a} - {1'b0, port_if.b} - {8'h00, bin};  // [RULE_02] [RULE_03]
      nib5  = {1'b0, port_if.a[3:0]} - {1'b0, port_if.b[3:0]} - {4'h0, bin};
      case (port_if.op)
         OPF_SUB, OPF_SBC:
         begin
            r             = diff9[7:0];
            f[FLAG_C_BIT] = diff9[8];                                 // [RULE_01] [RULE_04]
            f[FLAG_H_BIT] = nib5[4];                                  // [RULE_01] [RULE_04]
            f[FLAG_N_BIT] = 1'b1;                                     // [RULE_01] [RULE_04]
            f[FLAG_PV_BIT] = (port_if.a[7] ^ port_if.b[7]) &
                             (port_if.a[7] ^ diff9[7]);               // [RULE_01] [RULE_04]
         end
         OPF_AND:
         begin
            r              = port_if.a & port_if.b;                   // [RULE_06]
            f[FLAG_H_BIT]  = 1'b1;                                    // [RULE_07]
            f[FLAG_PV_BIT] = bal_parity_even(r);
         end
         OPF_OR:
         begin
            r              = port_if.a | port_if.b;                   // [RULE_08] [RULE_09]
            f[FLAG_PV_BIT] = bal_parity_even(r);
         end
         OPF_XOR:
         begin
            r              = port_if.a ^ port_if.b;                   // [RULE_10]
            f[FLAG_PV_BIT] = bal_parity_even(r);                      // [RULE_11]
         end
         default:
         begin
            r = port_if.a;
         end
      endcase
      f[FLAG_S_BIT] = r[7];                                           // [RULE_05]
      f[FLAG_Z_BIT] = (r == 8'h00);                                   // [RULE_05]
      port_if.res   = r;
      port_if.flags = f;
   end

endmodule

`default_nettype wire

// ===== src/bal_core.sv
// Purpose: sequencer of the borrow and logic accumulator operations
// Assumes: decoder presents prefix, opcode and argument bytes with a start pulse;
//          register file and memory answer within the machine cycle asked
// Notes:   accumulator and flag byte live here; one operation at a time
`timescale 1ns/100ps
`default_nettype none

module bal_core
   import bal_pkg::*;
#(
   parameter int unsigned T_DIV = T_DIV_DEFAULT
)
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic        start,
   input  wire logic [7:0]  prefix_byte,
   input  wire logic [7:0]  opcode_byte,
   input  wire logic [7:0]  arg_byte,
   input  wire logic [7:0]  reg_rd_data,
   input  wire logic [15:0] pointer_pair,
   input  wire logic [15:0] first_index_pair,
   input  wire logic [15:0] second_index_pair,
   input  wire logic [7:0]  mem_rd_data,
   input  wire logic        acc_load,
   input  wire logic [7:0]  acc_load_data,
   input  wire logic        flags_load,
   input  wire logic [7:0]  flags_load_data,
   output var  logic [7:0]  acc_reg,
   output var  logic [7:0]  flags_reg,
   output var  logic        busy_reg,
   output var  logic        done_reg,
   output var  logic        bad_op_reg,
   output var  logic        t_tick_reg,
   output var  logic [2:0]  reg_sel_reg,
   output var  logic        mem_rd_reg,
   output var  logic [15:0] mem_addr_reg
);

   // ---
   // local constants and state
   // ---
   localparam logic [4:0] T_DIV_LAST = 5'(T_DIV - 1);

   bal_state_e state_reg;
   bal_form_e  form_reg;
   logic [2:0] op_reg;
   logic [4:0] div_reg;
   logic [4:0] t_cnt_reg;
   logic [4:0] t_total_reg;
   logic [7:0] opnd_reg;
   logic [7:0] arg_reg;

   logic       dec_ok;
   bal_form_e  dec_form;
   logic [4:0] dec_total;
   logic [15:0] dec_addr;
   logic       tick;
   logic       last_tick;
   logic       mem_start_tick;
   logic       take;

   bal_alu_if alu_if ();

   bal_alu u_alu
   (
      .port_if (alu_if)
   );

   // ---
   // decode of the presented instruction
   // ---
   always_comb
   begin
      logic [1:0] row;
      logic [2:0] opf;
      logic [2:0] fld;
      logic       plain;
      logic       indexed;
      row     = opcode_byte[7:6];
      opf     = opcode_byte[5:3];
      fld     = opcode_byte[2:0];
      plain   = (prefix_byte == PREFIX_NONE);
      indexed = (prefix_byte == PREFIX_FIRST_IDX) || (prefix_byte == PREFIX_SECOND_IDX); // [RULE_13]
      dec_ok  = 1'b0;
      dec_form = FORM_REG;
      if (plain && (row == ROW_REG) && bal_op_known(opf))             // [RULE_16]
      begin
         dec_ok   = 1'b1;
         dec_form = (fld == PTR_FIELD) ? FORM_PTR : FORM_REG;         // [RULE_13]
      end
      else if (plain && (row == ROW_IMM) && (fld == PTR_FIELD) && bal_op_known(opf))
      begin
         // immediate opcodes d6, de, e6, f6, ee share this row
         dec_ok   = 1'b1;                                             // [RULE_03] [RULE_06] [RULE_08] [RULE_17]
         dec_form = FORM_IMM;
      end
      else if (indexed && (row == ROW_REG) && (fld == PTR_FIELD) && bal_op_known(opf))
      begin
         dec_ok   = 1'b1;                                             // [RULE_13]
         dec_form = FORM_IDX;
      end
   end

   always_comb
   begin
      case (dec_form)
         FORM_REG: dec_total = T_REG_FORM;                            // [RULE_15]
         FORM_IDX: dec_total = T_INDEX_FORM;                          // [RULE_15]
         default:  dec_total = T_SHORT_FORM;                          // [RULE_15]
      endcase
   end

   // signed displacement; the 16-bit sum wraps like the address bus
   always_comb
   begin
      logic [15:0] base;
      base = (prefix_byte == PREFIX_SECOND_IDX) ? second_index_pair : first_index_pair;
      if (dec_form == FORM_IDX)
      begin
         dec_addr = base + {{8{arg_byte[7]}}, arg_byte};              // [RULE_14]
      end
      else
      begin
         dec_addr = pointer_pair;
      end
   end

   assign take           = start && (state_reg == ST_IDLE);
   assign tick           = (state_reg == ST_RUN) && (div_reg == T_DIV_LAST);
   assign last_tick      = tick && (t_cnt_reg == 5'(t_total_reg - 5'h01));
   // memory is read in the final three-state machine cycle of each memory form
   assign mem_start_tick = tick && (form_reg == FORM_PTR || form_reg == FORM_IDX) &&
                           (5'(t_cnt_reg + 5'h01) == 5'(t_total_reg - T_MEM_CYCLE));

   // ---
   // sequencer
   // ---
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         state_reg <= ST_IDLE;
      end
      else
      begin
         case (state_reg)
            ST_IDLE:
            begin
               if (take && dec_ok)
               begin
                  state_reg <= ST_RUN;
               end
            end
            ST_RUN:
            begin
               if (last_tick)
               begin
                  state_reg <= ST_DONE;
               end
            end
            ST_DONE:
            begin
               state_reg <= ST_IDLE;
            end
            default:
            begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // t state divider restarts with each operation so timing is exact
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         div_reg    <= 5'h00;
         t_cnt_reg  <= 5'h00;
         t_tick_reg <= 1'b0;
      end
      else
      begin
         t_tick_reg <= tick;
         if (state_reg != ST_RUN)
         begin
            div_reg   <= 5'h00;
            t_cnt_reg <= 5'h00;
         end
         else if (tick)
         begin
            div_reg   <= 5'h00;
            t_cnt_reg <= 5'(t_cnt_reg + 5'h01);                       // [RULE_15]
         end
         else
         begin
            div_reg <= 5'(div_reg + 5'h01);
         end
      end
   end

   // latch of the decoded instruction
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         form_reg     <= FORM_REG;
         op_reg       <= OPF_SUB;
         t_total_reg  <= T_REG_FORM;
         arg_reg      <= 8'h00;
         reg_sel_reg  <= REG_B;
         mem_addr_reg <= 16'h0000;
         busy_reg     <= 1'b0;
         bad_op_reg   <= 1'b0;
      end
      else
      begin
         bad_op_reg <= take && !dec_ok;
         if (take && dec_ok)
         begin
            form_reg     <= dec_form;
            op_reg       <= opcode_byte[5:3];                         // [RULE_16]
            t_total_reg  <= dec_total;
            arg_reg      <= arg_byte;
            reg_sel_reg  <= opcode_byte[2:0];                         // [RULE_12]
            mem_addr_reg <= dec_addr;                                 // [RULE_14]
            busy_reg     <= 1'b1;
         end
         else if (state_reg == ST_DONE)
         begin
            busy_reg <= 1'b0;
         end
      end
   end

   // ---
   // operand fetch
   // ---
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         mem_rd_reg <= 1'b0;
         opnd_reg   <= 8'h00;
      end
      else
      begin
         mem_rd_reg <= mem_start_tick;
         if (last_tick)
         begin
            case (form_reg)
               FORM_REG:
               begin
                  // the accumulator field reads the accumulator itself
                  opnd_reg <= (reg_sel_reg == REG_A) ? acc_reg : reg_rd_data; // [RULE_12]
               end
               FORM_IMM:
               begin
                  opnd_reg <= arg_reg;                                // [RULE_13]
               end
               default:
               begin
                  opnd_reg <= mem_rd_data;                            // [RULE_13]
               end
            endcase
         end
      end
   end

   // ---
   // write back
   // ---
   assign alu_if.op  = op_reg;
   assign alu_if.a   = acc_reg;
   assign alu_if.b   = opnd_reg;
   assign alu_if.cin = flags_reg[FLAG_C_BIT];                         // [RULE_03]

   // write back beats an outside load in the same cycle
   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         acc_reg   <= ACC_RESET;
         flags_reg <= FLAGS_RESET;
         done_reg  <= 1'b0;
      end
      else
      begin
         done_reg <= (state_reg == ST_DONE);
         if (state_reg == ST_DONE)
         begin
            acc_reg   <= alu_if.res;                                  // [RULE_02] [RULE_06] [RULE_10]
            flags_reg <= alu_if.flags;                                // [RULE_05] [RULE_09]
         end
         else
         begin
            if (acc_load)
            begin
               acc_reg <= acc_load_data;
            end
            if (flags_load)
            begin
               flags_reg <= flags_load_data;
            end
         end
      end
   end

endmodule

`default_nettype wire

// ===== dv/bal_core_assertions.sv
// Purpose: port-level timing and flag checks for the accumulator sequencer
// Assumes: one clock, synchronous active-high reset
// Notes:   operand form is latched at each start taken while idle
`timescale 1ns/100ps
`default_nettype none

module bal_core_assertions
   import bal_pkg::*;
#(
   parameter int unsigned T_DIV = 2
)
(
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        start,
   input wire logic [7:0]  prefix_byte,
   input wire logic [7:0]  opcode_byte,
   input wire logic [7:0]  arg_byte,
   input wire logic [15:0] pointer_pair,
   input wire logic [15:0] first_index_pair,
   input wire logic [15:0] second_index_pair,
   input wire logic [7:0]  acc_reg,
   input wire logic [7:0]  flags_reg,
   input wire logic        busy_reg,
   input wire logic        done_reg,
   input wire logic        t_tick_reg,
   input wire logic        bad_op_reg,
   input wire logic        mem_rd_reg,
   input wire logic [15:0] mem_addr_reg
);
   // ---
   // latched operation
   // ---
   localparam int LAT_REG   = 4 * T_DIV + 1;
   localparam int LAT_SHORT = 7 * T_DIV + 1;
   localparam int LAT_IDX   = 19 * T_DIV + 1;
   logic [7:0]  op_reg;
   logic [7:0]  pf_reg;
   logic [15:0] addr_reg;
   logic [2:0]  opf;
   logic        is_idx;
   logic        is_reg;
   logic [15:0] disp;
   assign opf = op_reg[5:3];
   assign is_idx = pf_reg != 8'h00;
   assign is_reg = !is_idx && op_reg[7:6] == ROW_REG && op_reg[2:0] != PTR_FIELD;
   assign disp = {{8{arg_byte[7]}}, arg_byte};

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         op_reg   <= 8'h00;
         pf_reg   <= 8'h00;
         addr_reg <= 16'h0000;
      end
      else if (start && !busy_reg)
      begin
         op_reg   <= opcode_byte;
         pf_reg   <= prefix_byte;
         addr_reg <= (prefix_byte == PREFIX_FIRST_IDX) ? first_index_pair + disp :
                     (prefix_byte == PREFIX_SECOND_IDX) ? second_index_pair + disp :
                     pointer_pair;
      end
   end

   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   reg_latency_a: assert property ($rose(busy_reg) && is_reg |-> ##LAT_REG done_reg)
      else $error("register form latency wrong");
   short_latency_a: assert property ($rose(busy_reg) && !is_idx && !is_reg |-> ##LAT_SHORT done_reg)
      else $error("short form latency wrong");
   idx_latency_a: assert property ($rose(busy_reg) && is_idx |-> ##LAT_IDX done_reg)
      else $error("indexed form latency wrong");
   done_pulse_a: assert property (done_reg |-> !busy_reg ##1 !done_reg)
      else $error("done not a single idle pulse");
   sign_zero_a: assert property (done_reg |-> flags_reg[FLAG_S_BIT] == acc_reg[7] && flags_reg[FLAG_Z_BIT] == (acc_reg == 8'h00))
      else $error("sign or zero flag wrong");
   sub_flag_a: assert property (done_reg && (opf == OPF_SUB || opf == OPF_SBC) |-> flags_reg[FLAG_N_BIT])
      else $error("subtract flag not set");
   and_flags_a: assert property (done_reg && opf == OPF_AND |-> flags_reg[FLAG_H_BIT] && !flags_reg[FLAG_N_BIT] && !flags_reg[FLAG_C_BIT])
      else $error("and flags wrong");
   or_flags_a: assert property (done_reg && opf == OPF_OR |-> !flags_reg[FLAG_H_BIT] && !flags_reg[FLAG_N_BIT] && !flags_reg[FLAG_C_BIT])
      else $error("or flags wrong");
   xor_flags_a: assert property (done_reg && opf == OPF_XOR |-> flags_reg[FLAG_PV_BIT] == ~^acc_reg && flags_reg[4:0] == {1'b0, 1'b0, ~^acc_reg, 2'b00})
      else $error("xor flags wrong");
   mem_addr_a: assert property (mem_rd_reg |-> mem_addr_reg == addr_reg)
      else $error("memory address wrong");
   tick_first_a: assert property ($rose(busy_reg) |-> ##T_DIV t_tick_reg)
      else $error("first t state tick late");

   cover property ($rose(busy_reg) && is_reg);
   cover property ($rose(busy_reg) && is_idx);
   cover property (bad_op_reg);
endmodule

`default_nettype wire

// ===== dv/bal_far_model.sv
// Purpose: register file and memory seen by the accumulator sequencer
// Assumes: memory byte is a fixed function of its address
// Notes:   memory data toggles when no read is open, so stale reads show
`timescale 1ns/100ps
`default_nettype none

module bal_far_model
   import bal_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        sys_rst,
   input  wire logic [2:0]  reg_sel_reg,
   input  wire logic [7:0]  acc_reg,
   input  wire logic        mem_rd_reg,
   input  wire logic        done_reg,
   input  wire logic [15:0] mem_addr_reg,
   output logic      [7:0]  reg_rd_data,
   output logic      [7:0]  mem_rd_data
);
   // ---
   // register file and memory
   // ---
   logic hold_reg;
   assign reg_rd_data = (reg_sel_reg == REG_A) ? acc_reg : 8'h11 * ({5'h00, reg_sel_reg} + 8'h01);

   always_ff @(posedge core_clk)
   begin
      if (sys_rst)
      begin
         hold_reg    <= 1'b0;
         mem_rd_data <= 8'h00;
      end
      else if (mem_rd_reg)
      begin
         hold_reg    <= 1'b1;
         mem_rd_data <= mem_addr_reg[7:0] ^ mem_addr_reg[15:8] ^ 8'ha5;
      end
      else if (done_reg)
         hold_reg <= 1'b0;
      else if (!hold_reg)
         mem_rd_data <= ~mem_rd_data;
   end
endmodule

`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: self-checking bench of the accumulator sequencer
// Assumes: T state shortened to 2 clocks
// Notes:   expected results come from a local reference function
`timescale 1ns/100ps
`default_nettype none

module tb_top
   import bal_pkg::*;
;
   localparam int TD = 2;
   logic        core_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        start = 1'b0;
   logic [7:0]  prefix_byte = 8'h00;
   logic [7:0]  opcode_byte = 8'h00;
   logic [7:0]  arg_byte = 8'h00;
   logic [15:0] pointer_pair = 16'h0000;
   logic [15:0] first_index_pair = 16'h0000;
   logic [15:0] second_index_pair = 16'h0000;
   logic        acc_load = 1'b0;
   logic [7:0]  acc_load_data = 8'h00;
   logic        flags_load = 1'b0;
   logic [7:0]  flags_load_data = 8'h00;
   logic [7:0]  reg_rd_data, mem_rd_data, acc_reg, flags_reg;
   logic        busy_reg, done_reg, bad_op_reg, mem_rd_reg;
   logic [2:0]  reg_sel_reg;
   logic [15:0] mem_addr_reg;
   int          failures = 0;
   int          check_count = 0;
   int          cycles = 0;

   bal_core #(.T_DIV(TD)) bal_core_inst (.core_clk, .sys_rst, .start, .prefix_byte,
      .opcode_byte, .arg_byte, .reg_rd_data, .pointer_pair, .first_index_pair,
      .second_index_pair, .mem_rd_data, .acc_load, .acc_load_data, .flags_load,
      .flags_load_data, .acc_reg, .flags_reg, .busy_reg, .done_reg, .bad_op_reg,
      .t_tick_reg(), .reg_sel_reg, .mem_rd_reg, .mem_addr_reg);
   bal_far_model bal_far_model_inst (.core_clk, .sys_rst, .reg_sel_reg, .acc_reg,
      .mem_rd_reg, .done_reg, .mem_addr_reg, .reg_rd_data, .mem_rd_data);

   always #5 core_clk = ~core_clk;

   // ---
   // helpers
   // ---
   task automatic tick;
      @(posedge core_clk);
      #1;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
      check_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   function automatic logic [7:0] memv(input logic [15:0] ad);
      return ad[7:0] ^ ad[15:8] ^ 8'ha5;
   endfunction

   function automatic logic [15:0] model(input logic [2:0] opf, input logic [7:0] a,
                                         input logic [7:0] b, input logic cin);
      logic       c;
      logic [8:0] d;
      logic [4:0] h;
      logic [7:0] r;
      logic [7:0] f;
      c = cin && opf == OPF_SBC;
      d = {1'b0, a} - {1'b0, b} - {8'h00, c};
      h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, c};
      r = (opf == OPF_AND) ? a & b : (opf == OPF_OR) ? a | b : (opf == OPF_XOR) ? a ^ b : d[7:0];
      f = {r[7], r == 8'h00, 1'b0, opf == OPF_AND, 1'b0, ~^r, 2'b00};
      if (opf == OPF_SUB || opf == OPF_SBC)
         f[4:0] = {h[4], 1'b0, (a[7] ^ b[7]) & (a[7] ^ r[7]), 1'b1, d[8]};
      return {r, f};
   endfunction

   // extra start pulse at cycle poke, while busy, must be ignored
   task automatic run(input logic [7:0] pf, input logic [7:0] op, input logic [7:0] arg,
                      input int poke, output int cyc);
      prefix_byte = pf;
      opcode_byte = op;
      arg_byte = arg;
      start = 1'b1;
      cyc = 0;
      do
      begin
         tick;
         cyc++;
         if (done_reg !== 1'b1)
            start = (cyc == poke);
      end
      while (done_reg !== 1'b1 && cyc < 100);
   endtask

   task automatic do_op(input logic [7:0] pf, input logic [7:0] op, input logic [7:0] arg,
                        input logic [7:0] a, input logic [7:0] b, input logic cin, input int n);
      int cyc;
      acc_load = 1'b1;
      acc_load_data = a;
      flags_load = 1'b1;
      flags_load_data = {7'h00, cin};
      tick;
      acc_load = 1'b0;
      flags_load = 1'b0;
      run(pf, op, arg, 0, cyc);
      chk({acc_reg, flags_reg}, model(op[5:3], a, b, cin), "result");
      chk(16'(cyc), 16'(n * TD + 2), "latency");
   endtask

   // ---
   // scenarios
   // ---
   task automatic sc_reset;
      chk({acc_reg, flags_reg}, 16'h0000, "reset acc flags");
      chk({busy_reg, done_reg, bad_op_reg, mem_rd_reg, reg_sel_reg}, 16'h0000, "reset ctl");
      chk(mem_addr_reg, 16'h0000, "reset addr");
   endtask

   task automatic sc_reg;
      logic [2:0] ops [5] = '{OPF_SUB, OPF_SBC, OPF_AND, OPF_XOR, OPF_OR};
      logic [7:0] a;
      for (int i = 0; i < 5; i++)
         for (int r = 0; r < 8; r++)
            if (r != 6)
            begin
               a = 8'(8'h3c + r * 8'h29);
               do_op(8'h00, {2'b10, ops[i], 3'(r)}, 8'h00, a, (r == 7) ? a : 8'(8'h11 * (r + 1)), r[0], 4);
               chk(reg_sel_reg, 16'(r), "reg field");
            end
   endtask

   task automatic sc_short;
      logic [7:0]  tv [8][4] = '{'{8'hd6, 8'h29, 8'h11, 8'h18}, '{8'hde, 8'h16, 8'h05, 8'h10},
         '{8'hde, 8'h00, 8'h00, 8'hff}, '{8'hde, 8'h80, 8'h01, 8'h7f}, '{8'he6, 8'hc3, 8'h7b, 8'h43},
         '{8'hf6, 8'h12, 8'h48, 8'h5a}, '{8'hee, 8'h96, 8'h5d, 8'hcb}, '{8'hee, 8'h5a, 8'h5a, 8'h00}};
      logic        cv [8] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      logic [15:0] ad;
      for (int i = 0; i < 8; i++)
      begin
         do_op(8'h00, tv[i][0], tv[i][2], tv[i][1], tv[i][2], cv[i], 7);
         chk(acc_reg, tv[i][3], "immediate");
         ad = 16'h3433 + 16'(i);
         pointer_pair = ad;
         do_op(8'h00, tv[i][0] & 8'hbf, 8'h00, tv[i][1], memv(ad), cv[i], 7);
         chk(mem_addr_reg, ad, "pointer addr");
      end
   endtask

   task automatic sc_idx;
      logic [15:0] iv [4][5] = '{'{16'hdd, 16'h9e, 16'h05, 16'h1000, 16'h1005},
         '{16'hfd, 16'ha6, 16'h80, 16'h2000, 16'h1f80}, '{16'hdd, 16'hb6, 16'hff, 16'h0000, 16'hffff},
         '{16'hfd, 16'hae, 16'h7f, 16'hfff0, 16'h006f}};
      for (int i = 0; i < 4; i++)
      begin
         first_index_pair = (iv[i][0] == 16'hdd) ? iv[i][3] : ~iv[i][3];
         second_index_pair = ~first_index_pair;
         do_op(iv[i][0][7:0], iv[i][1][7:0], iv[i][2][7:0], 8'h6b, memv(iv[i][4]), 1'b1, 19);
         chk(mem_addr_reg, iv[i][4], "index addr");
      end
   endtask

   task automatic sc_chain;
      int cyc;
      do_op(8'h00, 8'hd6, 8'h10, 8'h40, 8'h10, 1'b0, 7);
      run(8'h00, 8'hd6, 8'h10, 3, cyc);
      chk(acc_reg, 8'h20, "busy start ignored");
      chk(16'(cyc), 16'(7 * TD + 2), "latency");
      run(8'h00, 8'he6, 8'hf0, 0, cyc);
      chk({acc_reg, flags_reg}, model(OPF_AND, 8'h20, 8'hf0, 1'b0), "back to back");
   endtask

   task automatic sc_bad;
      logic [7:0] bv [4][2] = '{'{8'h00, 8'h80}, '{8'hdd, 8'ha0}, '{8'h00, 8'he0}, '{8'h12, 8'ha6}};
      logic [7:0] keep;
      keep = acc_reg;
      for (int i = 0; i < 4; i++)
      begin
         prefix_byte = bv[i][0];
         opcode_byte = bv[i][1];
         start = 1'b1;
         tick;
         start = 1'b0;
         chk({bad_op_reg, busy_reg}, 16'h0002, "refused op");
         tick;
         chk(acc_reg, keep, "acc kept");
      end
   endtask

   task automatic results;
      if (failures == 0 && check_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   always @(posedge core_clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         failures++;
         results();
      end
   end

   initial
   begin
      repeat (12) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      sc_reset();
      sc_reg();
      sc_short();
      sc_idx();
      sc_chain();
      sc_bad();
      results();
   end
endmodule

bind bal_core bal_core_assertions #(.T_DIV(T_DIV)) bal_core_assertions_inst (.core_clk,
   .sys_rst, .start, .prefix_byte, .opcode_byte, .arg_byte, .pointer_pair,
   .first_index_pair, .second_index_pair, .acc_reg, .flags_reg, .busy_reg, .done_reg,
   .bad_op_reg, .mem_rd_reg, .mem_addr_reg, .t_tick_reg);

`default_nettype wire
